// File: logic/timer_combine_defs.vh
// constants for the shared timer function control block
// assumes a single 50 MHz clock and an 8-bit register port
`ifndef TIMER_COMBINE_DEFS_VH
`define TIMER_COMBINE_DEFS_VH

// register map
`define CTRL_ADDR 8'h01
`define CTRL_RESET 8'h00
`define CTRL_STOP_KEEP_MASK 8'h30

// field positions
`define MODE_BIT 7
`define PIN_SEL_BIT 6
`define COMBINE_HI 5
`define COMBINE_LO 4
`define SUBMODE_HI 3
`define SUBMODE_LO 2
`define INIT8_BIT 1
`define INIT16_BIT 0

// field codes
`define COMBINE_AND 2'h0
`define COMBINE_OR 2'h1
`define COMBINE_NOR 2'h2
`define COMBINE_NAND 2'h3
`define SUB_NORMAL 2'h0
`define SUB_ALTERNATE 2'h1
`define SUB_FORCE_LOW 2'h2
`define SUB_FORCE_HIGH 2'h3
`define EDGE_FALL 2'h0
`define EDGE_RISE 2'h1
`define EDGE_BOTH 2'h2
`define FILT_OFF 2'h0
`define FILT_SHORT 2'h1
`define FILT_LONG 2'h2

// glitch filter widths in clock cycles
`define FILT_SHORT_CYCLES 4'h4
`define FILT_LONG_CYCLES 4'h8

`endif

// File: logic/timer_output_combine_demod_config.v
// shared control register and output/demod logic for the 8/16-bit timer pair
// assumes timer outputs, enable and demod input are synchronous to I_REF_CLK
// assumes software stops both timers before it flips the mode bit
`include "timer_combine_defs.vh"

module timer_output_combine_demod_config (
    // clock and reset
    input wire I_REF_CLK,
    input wire I_RESET_N,
    // register port
    input wire [7:0] I_ADDR,
    input wire [7:0] I_WDATA,
    input wire I_WR,
    input wire I_RD,
    output wire [7:0] O_RDATA,
    // power management
    input wire I_STOP_RECOVERY,
    // timer side
    input wire I_EIGHT_BIT_TIMER_OUT,
    input wire I_SIXTEEN_BIT_TIMER_OUT,
    input wire I_SIXTEEN_BIT_TIMER_RUN,
    // demodulator input
    input wire I_DEMOD_IN,
    // outputs
    output wire O_WIDE_TIMER_OUTPUT_PIN,
    output wire O_COMBINED_OUT,
    output wire O_ALTERNATING_ACTIVE,
    output wire O_DEMOD_MODE,
    output wire O_RISE_EDGE,
    output wire O_FALL_EDGE
);

    // filter threshold for a filter code; reserved code behaves as off
    // a zero limit lets a change through on its first differing sample
    function [3:0] filt_limit;
        input [1:0] code;
        begin
            case (code)
                `FILT_SHORT: filt_limit = `FILT_SHORT_CYCLES;
                `FILT_LONG: filt_limit = `FILT_LONG_CYCLES;
                default: filt_limit = 4'h0;
            endcase
        end
    endfunction

    // combine two timer outputs per the logic field
    function combine;
        input [1:0] code;
        input a;
        input b;
        begin
            case (code)
                `COMBINE_AND: combine = a & b;
                `COMBINE_OR: combine = a | b;
                `COMBINE_NOR: combine = ~(a | b);
                default: combine = ~(a & b);
            endcase
        end
    endfunction

    reg [7:0] ctrl_ff; // shared control register
    reg [7:0] nxt_ctrl;
    reg alt_ff; // alternating submode running
    reg nxt_alt;
    reg rise_flag_ff; // sticky rising edge flag
    reg fall_flag_ff; // sticky falling edge flag
    reg [7:0] rdata_ff; // read data, valid one cycle after strobe
    reg filt_ff; // filtered demod level
    reg filt_prev_ff; // filtered level one cycle ago
    reg [3:0] filt_cnt_ff; // cycles the raw input has disagreed
    reg wide_ff; // wide timer output pin
    reg comb_ff; // combined output
    reg rise_ff; // rising edge pulse
    reg fall_ff; // falling edge pulse
    reg wide_val; // next value of the wide output

    // address decode; only the one control register is mapped
    wire sel = (I_ADDR == `CTRL_ADDR);
    wire wr_ctrl = I_WR & sel;
    wire demod = ctrl_ff[`MODE_BIT];
    // shared fields change meaning with the mode bit
    wire [1:0] field54 = ctrl_ff[`COMBINE_HI:`COMBINE_LO];
    wire [1:0] field32 = ctrl_ff[`SUBMODE_HI:`SUBMODE_LO];
    wire [1:0] wr_sub = I_WDATA[`SUBMODE_HI:`SUBMODE_LO];
    // edge detector qualified by code; reserved code detects nothing
    wire rise_det = demod & filt_ff & ~filt_prev_ff &
        ((field54 == `EDGE_RISE) | (field54 == `EDGE_BOTH));
    wire fall_det = demod & ~filt_ff & filt_prev_ff &
        ((field54 == `EDGE_FALL) | (field54 == `EDGE_BOTH));

    // register write decode, stop recovery and alternating state
    always @* begin
        nxt_ctrl = ctrl_ff;
        nxt_alt = alt_ff;
        if (I_STOP_RECOVERY) begin
            // combine field is kept, everything else returns to reset
            // a write in the same cycle is lost apart from its edge flag clears; recovery wins
            nxt_ctrl = (ctrl_ff & `CTRL_STOP_KEEP_MASK) |
                (`CTRL_RESET & ~`CTRL_STOP_KEEP_MASK);
            nxt_alt = 1'b0;
        end else if (wr_ctrl) begin
            if (demod && I_WDATA[`MODE_BIT]) begin
                // low bits are edge flags here; keep the stored initial levels
                nxt_ctrl = {I_WDATA[7:2], ctrl_ff[1:0]};
            end else begin
                nxt_ctrl = I_WDATA;
            end
            // submode meaning applies only for a transmit-mode write
            if (!I_WDATA[`MODE_BIT]) begin
                if (wr_sub == `SUB_ALTERNATE) begin
                    nxt_alt = 1'b1;
                end else begin
                    nxt_alt = 1'b0;
                end
            end else begin
                nxt_alt = 1'b0;
            end
        end
    end

    // wide output: forced, held inverted while idle, or timer output
    // forced codes ignore the run level so the pin can be parked
    always @* begin
        case (field32)
            `SUB_FORCE_LOW: wide_val = 1'b0;
            `SUB_FORCE_HIGH: wide_val = 1'b1;
            default: begin
                if (I_SIXTEEN_BIT_TIMER_RUN) begin
                    wide_val = I_SIXTEEN_BIT_TIMER_OUT;
                end else begin
                    wide_val = ~ctrl_ff[`INIT16_BIT];
                end
            end
        endcase
    end

    // control state and register read
    // read data drops back to zero so a stale value is never taken twice
    always @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            ctrl_ff <= `CTRL_RESET;
            alt_ff <= 1'b0;
            rdata_ff <= 8'h00;
        end else begin
            ctrl_ff <= nxt_ctrl;
            alt_ff <= nxt_alt;
            if (I_RD && sel) begin
                // demod mode shows the edge flags in the low bits
                rdata_ff <= demod ? {ctrl_ff[7:2], rise_flag_ff, fall_flag_ff} : ctrl_ff;
            end else begin
                rdata_ff <= 8'h00;
            end
        end
    end

    // glitch filter: a change passes once it outlasts the limit
    // the count restarts whenever the raw input agrees again, so only
    // an unbroken run of the new level is accepted
    // the limit follows the filter code live; change it only while idle
    always @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            filt_ff <= 1'b0;
            filt_prev_ff <= 1'b0;
            filt_cnt_ff <= 4'h0;
        end else begin
            filt_prev_ff <= filt_ff;
            if (I_DEMOD_IN == filt_ff) begin
                filt_cnt_ff <= 4'h0; // glitch ended, start over
            end else if (filt_cnt_ff >= filt_limit(field32)) begin
                filt_ff <= I_DEMOD_IN;
                filt_cnt_ff <= 4'h0;
            end else begin
                filt_cnt_ff <= filt_cnt_ff + 4'h1;
            end
        end
    end

    // sticky edge flags; a new edge wins over a same-cycle clear
    // software clears a flag by writing a one to it in demod mode
    always @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            rise_flag_ff <= 1'b0;
            fall_flag_ff <= 1'b0;
        end else begin
            if (rise_det) begin
                rise_flag_ff <= 1'b1;
            end else if (wr_ctrl && demod && I_WDATA[`INIT8_BIT]) begin
                rise_flag_ff <= 1'b0;
            end
            if (fall_det) begin
                fall_flag_ff <= 1'b1;
            end else if (wr_ctrl && demod && I_WDATA[`INIT16_BIT]) begin
                fall_flag_ff <= 1'b0;
            end
        end
    end

    // registered outputs
    // the combined output uses the same wide level that feeds the pin
    // edge pulses come one edge after the edge detector fires
    always @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            wide_ff <= 1'b0;
            comb_ff <= 1'b0;
            rise_ff <= 1'b0;
            fall_ff <= 1'b0;
        end else begin
            // outputs idle low in demod mode; timers are then capturing
            wide_ff <= demod ? 1'b0 : wide_val;
            comb_ff <= demod ? 1'b0 :
                combine(field54, I_EIGHT_BIT_TIMER_OUT, wide_val);
            rise_ff <= rise_det;
            fall_ff <= fall_det;
        end
    end

    // ports come straight from the flip-flops above
    assign O_RDATA = rdata_ff;
    assign O_WIDE_TIMER_OUTPUT_PIN = wide_ff;
    assign O_COMBINED_OUT = comb_ff;
    assign O_ALTERNATING_ACTIVE = alt_ff;
    assign O_DEMOD_MODE = ctrl_ff[`MODE_BIT];
    assign O_RISE_EDGE = rise_ff;
    assign O_FALL_EDGE = fall_ff;

endmodule

// File: sim/ir_pin_model.sv
// receive pin model for the demodulator input
// assumes the bench calls send with a level and a width in clocks
module ir_pin_model (
    // clock and receive pin
    input wire clk,
    output logic o_rx
);
    timeunit 1ns;
    timeprecision 1ps;
    // line idles low, changes only just after a rising edge
    initial o_rx = 1'b0;
    // hold lvl for n sampled cycles; n sets quick or slow answers
    task send(input logic lvl, input int n);
        @(posedge clk);
        o_rx <= lvl;
        repeat (n - 1) @(posedge clk);
    endtask
endmodule

// File: sim/timer_combine_properties.sv
// port assertions for the shared timer control block
// assumes it is bound onto the top design module
module timer_combine_checker (
    // clock, reset and inputs
    input wire I_REF_CLK,
    input wire I_RESET_N,
    input wire [7:0] I_ADDR,
    input wire [7:0] I_WDATA,
    input wire I_WR,
    input wire I_RD,
    input wire I_STOP_RECOVERY,
    input wire I_SIXTEEN_BIT_TIMER_RUN,
    // outputs
    input wire [7:0] O_RDATA,
    input wire O_WIDE_TIMER_OUTPUT_PIN,
    input wire O_COMBINED_OUT,
    input wire O_ALTERNATING_ACTIVE,
    input wire O_DEMOD_MODE,
    input wire O_RISE_EDGE,
    input wire O_FALL_EDGE
);
    timeunit 1ns;
    timeprecision 1ps;
    // a write that stop recovery does not swallow
    wire hit = I_WR && (I_ADDR == 8'h01) && !I_STOP_RECOVERY;
    wire tx = hit && !I_WDATA[7];
    default clocking @(posedge I_REF_CLK);
    endclocking
    default disable iff (!I_RESET_N);
    chk_force_low: assert property (tx && I_WDATA[3:2] == 2'h2 |->
        ##2 !O_WIDE_TIMER_OUTPUT_PIN)
        else $error("wide pin not forced low");
    chk_force_high: assert property (tx && I_WDATA[3:2] == 2'h3 |->
        ##2 O_WIDE_TIMER_OUTPUT_PIN)
        else $error("wide pin not forced high");
    chk_alt_start: assert property (tx && I_WDATA[3:2] == 2'h1 |=> O_ALTERNATING_ACTIVE)
        else $error("alternating submode not entered");
    chk_alt_end: assert property (tx && I_WDATA[3:2] == 2'h0 |=> !O_ALTERNATING_ACTIVE)
        else $error("alternating submode not ended");
    chk_demod_quiet: assert property (hit && I_WDATA[7] |=>
        O_DEMOD_MODE ##1 (!O_COMBINED_OUT && !O_WIDE_TIMER_OUTPUT_PIN))
        else $error("transmit outputs active in demod mode");
    chk_wide_idle: assert property (tx && I_WDATA[3:2] == 2'h0
        ##1 !I_SIXTEEN_BIT_TIMER_RUN
        |=> O_WIDE_TIMER_OUTPUT_PIN == !$past(I_WDATA[0], 2))
        else $error("idle wide pin not inverse of initial bit");
    chk_rdata_idle: assert property (!I_RD |=> O_RDATA == 8'h00)
        else $error("read data outside read cycle");
    chk_edge_tx_quiet: assert property (!O_DEMOD_MODE |=> !O_RISE_EDGE && !O_FALL_EDGE)
        else $error("edge pulse in transmit mode");
    cover property (O_RISE_EDGE);
    cover property (O_FALL_EDGE);
    cover property (O_ALTERNATING_ACTIVE);
endmodule
bind timer_output_combine_demod_config timer_combine_checker u_chk (.*);

// File: sim/testbench.sv
// self-checking bench for the shared timer control block
// assumes a 50 MHz clock and the receive pin model
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, reset_n, wr, rd, stop, t8, t16, run;
    logic [7:0] addr, wdata, got;
    wire [7:0] rdata;
    wire rx, wide, comb, alt, demod, rise, fall;
    int fail_count, samples_checked, rise_cnt, fall_cnt;
    ir_pin_model i_pins (.clk(ref_clk), .o_rx(rx));
    timer_output_combine_demod_config i_dut (.I_REF_CLK(ref_clk), .I_RESET_N(reset_n),
        .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
        .I_STOP_RECOVERY(stop), .I_EIGHT_BIT_TIMER_OUT(t8), .I_SIXTEEN_BIT_TIMER_OUT(t16),
        .I_SIXTEEN_BIT_TIMER_RUN(run), .I_DEMOD_IN(rx), .O_WIDE_TIMER_OUTPUT_PIN(wide),
        .O_COMBINED_OUT(comb), .O_ALTERNATING_ACTIVE(alt), .O_DEMOD_MODE(demod),
        .O_RISE_EDGE(rise), .O_FALL_EDGE(fall));
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // count edge pulses so multi-pulse faults show up
    always @(posedge ref_clk) begin
        rise_cnt += rise;
        fall_cnt += fall;
    end
    task check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    // read data is only valid in the cycle after the strobe
    task rd_reg(input logic [7:0] a);
        @(posedge ref_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd <= 1'b0;
        @(negedge ref_clk);
        got = rdata;
    endtask
    task t_regs;
        rd_reg(8'h01);
        check(got, 8'h00);
        wr_reg(8'h01, 8'h75);
        rd_reg(8'h01);
        check(got, 8'h75);
        rd_reg(8'h02);
        check(got, 8'h00);
    endtask
    // forced wide level stands in for the sixteen-bit output
    task t_combine;
        logic e;
        for (int c = 0; c < 4; c++)
            for (int v = 0; v < 4; v++) begin
                @(posedge ref_clk);
                t8 <= v[0];
                wr_reg(8'h01, 8'(8'h08 | (c << 4) | (v[1] << 2)));
                repeat (3) @(posedge ref_clk);
                @(negedge ref_clk);
                // and, or, nor, nand in code order
                e = ((c[0] ^ c[1]) ? v[0] | v[1] : v[0] & v[1]) ^ c[1];
                check({7'h0, comb}, {7'h0, e});
                check({7'h0, wide}, {7'h0, v[1]});
            end
    endtask
    task t_submode;
        wr_reg(8'h01, 8'h04);
        @(negedge ref_clk);
        check({7'h0, alt}, 8'h01);
        wr_reg(8'h01, 8'h01);
        @(negedge ref_clk);
        check({7'h0, alt}, 8'h00);
        repeat (2) @(negedge ref_clk);
        check({7'h0, wide}, 8'h00);
        @(posedge ref_clk);
        run <= 1'b1;
        t16 <= 1'b1;
        repeat (3) @(negedge ref_clk);
        check({7'h0, wide}, 8'h01);
        @(posedge ref_clk);
        run <= 1'b0;
        t16 <= 1'b0;
    endtask
    task t_stop;
        wr_reg(8'h01, 8'h25);
        stop <= 1'b1;
        @(posedge ref_clk);
        stop <= 1'b0;
        rd_reg(8'h01);
        check(got, 8'h20);
        check({7'h0, alt}, 8'h00);
        check({7'h0, demod}, 8'h00);
    endtask
    // each row: setting, pulse width, expected rise and fall counts
    task t_demod;
        logic [7:0] cfg [9] = '{8'ha3, 8'ha7, 8'ha7, 8'ha8, 8'ha8, 8'h80, 8'h90, 8'hac, 8'hb0};
        int wid [9] = '{1, 4, 5, 8, 9, 1, 1, 1, 1};
        logic [1:0] ex [9] = '{2'h3, 2'h0, 2'h3, 2'h0, 2'h3, 2'h1, 2'h2, 2'h3, 2'h0};
        for (int i = 0; i < 9; i++) begin
            wr_reg(8'h01, cfg[i]);
            @(negedge ref_clk);
            rise_cnt = 0;
            fall_cnt = 0;
            i_pins.send(1'b1, wid[i]);
            i_pins.send(1'b0, 14);
            check(8'(rise_cnt), {7'h0, ex[i][1]});
            check(8'(fall_cnt), {7'h0, ex[i][0]});
        end
        rd_reg(8'h01);
        check(got, 8'hb3);
        check({7'h0, demod}, 8'h01);
        // writing a one to the falling flag clears only that flag
        wr_reg(8'h01, 8'hb1);
        rd_reg(8'h01);
        check(got, 8'hb2);
    endtask
    task results;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        {reset_n, wr, rd, stop, t8, t16, run} = 7'h0;
        addr = 8'h00;
        wdata = 8'h00;
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_regs;
        t_combine;
        t_submode;
        t_stop;
        t_demod;
        results;
    end
    // hang guard, well beyond the few hundred cycles the run needs
    initial begin
        repeat (4000) @(posedge ref_clk);
        fail_count++;
        results;
    end
endmodule
